// file: hw/rotc_pkg.sv
// Constants and types of the remote output terminal control block
package rotc_pkg;
  // Parameter numbers used on the parameter access port
  localparam logic [9:0] NUM_RETENTION_MODE = 10'h1EF;
  localparam logic [9:0] NUM_DATA_WORD_ONE = 10'h1F0;
  localparam logic [9:0] NUM_DATA_WORD_TWO = 10'h1F1;
  // Retention mode settings
  localparam logic [7:0] MODE_CLR_CLR = 8'h00;
  localparam logic [7:0] MODE_KEEP_CLR = 8'h01;
  localparam logic [7:0] MODE_CLR_KEEP = 8'h0A;
  localparam logic [7:0] MODE_KEEP_KEEP = 8'h0B;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Terminal function codes of the remote output function
  localparam logic [7:0] FUNC_REMOTE_POS = 8'h60;
  localparam logic [7:0] FUNC_REMOTE_NEG = 8'hC4;
  // Data word layout
  localparam int DATA_W = 12;
  localparam logic [11:0] DATA_RESET = 12'h000;
  localparam logic [11:0] DATA_MAX = 12'hFFF;
  localparam int BIT_RUN = 0;
  localparam int BIT_FU = 1;
  localparam int BIT_ABC = 3;
  localparam int RELAY_LSB = 4;
  localparam int RELAY_N = 3;
  localparam int EXT_LSB = 0;
  localparam int EXT_N = 7;
  localparam int TERM_N = 3;
  localparam int CODE_W = 8;
  // Write selector value that allows setting
  localparam logic [1:0] USER_GROUP_ALL = 2'h0;
  // Start-up sequence
  typedef enum logic [0:0] {ROTC_INIT, ROTC_RUN} rotc_state_type;
endpackage : rotc_pkg

// file: hw/rotc_term_cell.sv
// One output terminal: remote level or its own function by function code
`timescale 1ns/1ps
module rotc_term_cell
  import rotc_pkg::*;
(
  // Terminal setup
  input wire logic [rotc_pkg::CODE_W-1:0] func_code,
  input wire logic own_level,
  // Remote data bit for this terminal
  input wire logic remote_bit,
  // Resulting level
  output logic level
);
  import rotc_pkg::*;

  // Remote function only for the two remote codes
  always_comb
  begin
    if (func_code == FUNC_REMOTE_POS)
      level = remote_bit;
    else if (func_code == FUNC_REMOTE_NEG)
      level = ~remote_bit;
    else
      level = own_level;
  end
endmodule : rotc_term_cell

// file: hw/rotc_top.sv
// Remote output terminal control: data words, retention and terminal drive
`timescale 1ns/1ps
// Summary of operation
// - Mode 0,1,10,11: ones digit retains at power off, tens keeps at reset.
// - Terminal is remote-driven only with function code 96 or 196.
// - Two 12-bit data words; bit 1 turns output on, negative logic inverts.
// - Terminals without remote function follow their own function, except in modes 10 and 11 during a drive reset, where they hold.
// - Modes 0 and 10 clear outputs and both data words at power on.
// - Modes 1 and 11 save data before power off and restore it after.
// - No save on terminal or communication reset; save only at power off.
// - Modes 10 and 11 hold remote outputs unchanged throughout a drive reset.
// - Data words are written from panel-connector link or communication option.
// - Data words accept writes in any mode regardless of write protection.
// - Extension output bits act only with the extension option fitted.
// - Relay option bits act only with the relay option fitted.
// - Setting is allowed only while user group read selection is 0.
module rotc_top
  import rotc_pkg::*;
(
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Parameter write access from panel connector or option
  input wire logic panel_wr_en,
  input wire logic option_wr_en,
  input wire logic [9:0] wr_param_num,
  input wire logic [15:0] wr_data,
  output logic wr_ack,
  output logic wr_err,
  // Parameter read access
  input wire logic rd_en,
  input wire logic [9:0] rd_param_num,
  output logic [15:0] rd_data,
  // Drive settings
  input wire logic [1:0] user_group_read_selection,
  input wire logic parameter_write_protection,
  input wire logic [rotc_pkg::TERM_N*rotc_pkg::CODE_W-1:0]
    terminal_function_codes,
  input wire logic [rotc_pkg::TERM_N-1:0] own_function_levels,
  input wire logic ext_option_fitted,
  input wire logic relay_option_fitted,
  // Drive reset and power events
  input wire logic drive_reset,
  input wire logic power_fail,
  // Nonvolatile memory
  input wire logic [7:0] nvm_mode,
  input wire logic [11:0] nvm_word_one,
  input wire logic [11:0] nvm_word_two,
  output logic nvm_save,
  output logic [11:0] nvm_save_one,
  output logic [11:0] nvm_save_two,
  // Terminal outputs
  output logic [rotc_pkg::TERM_N-1:0] terminal_out,
  output logic [rotc_pkg::EXT_N-1:0] extension_output_bits,
  output logic [rotc_pkg::RELAY_N-1:0] relay_option_bits
);
  import rotc_pkg::*;

  rotc_state_type state_r;
  logic [7:0] remote_retention_mode_r;
  logic [11:0] remote_data_word_one_r;
  logic [11:0] remote_data_word_two_r;
  logic [11:0] word_one_nxt;
  logic [11:0] word_two_nxt;
  logic [7:0] mode_nxt;
  logic [TERM_N-1:0] level_nxt;
  logic [TERM_N-1:0] remote_bits;
  logic any_wr;
  logic wr_allowed;
  logic wr_ok;
  logic wr_value_ok;
  logic keep_at_reset;
  logic keep_at_power;
  logic power_fail_d_r;

  // Either link may write; write protection does not gate the data words
  assign any_wr = panel_wr_en | option_wr_en;
  assign wr_allowed = (user_group_read_selection == USER_GROUP_ALL)
    && (state_r == ROTC_RUN) && !drive_reset;

  // Range check per parameter
  always_comb
  begin
    wr_value_ok = 1'b0;
    if (wr_param_num == NUM_RETENTION_MODE)
      wr_value_ok = (wr_data == {8'h00, MODE_CLR_CLR})
        || (wr_data == {8'h00, MODE_KEEP_CLR})
        || (wr_data == {8'h00, MODE_CLR_KEEP})
        || (wr_data == {8'h00, MODE_KEEP_KEEP});
    else if (wr_param_num == NUM_DATA_WORD_ONE
      || wr_param_num == NUM_DATA_WORD_TWO)
      wr_value_ok = (wr_data <= {4'h0, DATA_MAX});
  end

  assign wr_ok = any_wr && wr_allowed && wr_value_ok;

  // Mode decode: ones digit for power off, tens digit for drive reset
  assign keep_at_power = (remote_retention_mode_r == MODE_KEEP_CLR)
    || (remote_retention_mode_r == MODE_KEEP_KEEP);
  assign keep_at_reset = (remote_retention_mode_r == MODE_CLR_KEEP)
    || (remote_retention_mode_r == MODE_KEEP_KEEP);

  // Next values of the stored parameters
  always_comb
  begin
    word_one_nxt = remote_data_word_one_r;
    word_two_nxt = remote_data_word_two_r;
    mode_nxt = remote_retention_mode_r;
    if (state_r == ROTC_INIT)
    begin
      mode_nxt = nvm_mode;
      if ((nvm_mode == MODE_KEEP_CLR) || (nvm_mode == MODE_KEEP_KEEP))
      begin
        word_one_nxt = nvm_word_one;
        word_two_nxt = nvm_word_two;
      end
      else
      begin
        word_one_nxt = DATA_RESET;
        word_two_nxt = DATA_RESET;
      end
    end
    else if (drive_reset)
    begin
      if (!keep_at_reset)
      begin
        word_one_nxt = DATA_RESET;
        word_two_nxt = DATA_RESET;
      end
    end
    else if (wr_ok)
    begin
      if (wr_param_num == NUM_RETENTION_MODE)
        mode_nxt = wr_data[7:0];
      else if (wr_param_num == NUM_DATA_WORD_ONE)
        word_one_nxt = wr_data[11:0];
      else
        word_two_nxt = wr_data[11:0];
    end
  end

  // Start-up: one cycle to pick up nonvolatile contents after release
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ROTC_INIT;
    else
      state_r <= ROTC_RUN;
  end

  // Stored parameters
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remote_retention_mode_r <= MODE_RESET;
      remote_data_word_one_r <= DATA_RESET;
      remote_data_word_two_r <= DATA_RESET;
    end
    else
    begin
      remote_retention_mode_r <= mode_nxt;
      remote_data_word_one_r <= word_one_nxt;
      remote_data_word_two_r <= word_two_nxt;
    end
  end

  // Write answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ack <= 1'b0;
      wr_err <= 1'b0;
    end
    else
    begin
      wr_ack <= wr_ok;
      wr_err <= any_wr && !wr_ok;
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 16'h0000;
    else if (rd_en)
    begin
      if (rd_param_num == NUM_RETENTION_MODE)
        rd_data <= {8'h00, remote_retention_mode_r};
      else if (rd_param_num == NUM_DATA_WORD_ONE)
        rd_data <= {4'h0, remote_data_word_one_r};
      else if (rd_param_num == NUM_DATA_WORD_TWO)
        rd_data <= {4'h0, remote_data_word_two_r};
      else
        rd_data <= 16'h0000;
    end
  end

  // Save to nonvolatile memory on the power fail edge only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_fail_d_r <= 1'b0;
      nvm_save <= 1'b0;
      nvm_save_one <= DATA_RESET;
      nvm_save_two <= DATA_RESET;
    end
    else
    begin
      power_fail_d_r <= power_fail;
      nvm_save <= power_fail && !power_fail_d_r && keep_at_power;
      nvm_save_one <= remote_data_word_one_r;
      nvm_save_two <= remote_data_word_two_r;
    end
  end

  // Remote bit of each terminal
  assign remote_bits[0] = word_one_nxt[BIT_RUN];
  assign remote_bits[1] = word_one_nxt[BIT_FU];
  assign remote_bits[2] = word_one_nxt[BIT_ABC];

  // One cell per terminal
  genvar t;
  generate
    for (t = 0; t < TERM_N; t++)
    begin : g_term
      rotc_term_cell u_cell
      (
        .func_code(terminal_function_codes[t*CODE_W +: CODE_W]),
        .own_level(own_function_levels[t]),
        .remote_bit(remote_bits[t]),
        .level(level_nxt[t])
      );
    end
  endgenerate

  // Terminal drive, following the next data value one cycle on
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      terminal_out <= '0;
    else if (drive_reset && keep_at_reset && state_r == ROTC_RUN)
      terminal_out <= terminal_out;
    else
      terminal_out <= level_nxt;
  end

  // Option outputs, gated by their options
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extension_output_bits <= '0;
      relay_option_bits <= '0;
    end
    else if (drive_reset && keep_at_reset && state_r == ROTC_RUN)
    begin
      extension_output_bits <= extension_output_bits;
      relay_option_bits <= relay_option_bits;
    end
    else
    begin
      extension_output_bits <= ext_option_fitted ?
        word_two_nxt[EXT_LSB +: EXT_N] : '0;
      relay_option_bits <= relay_option_fitted ?
        word_one_nxt[RELAY_LSB +: RELAY_N] : '0;
    end
  end
endmodule : rotc_top

// file: sim/rotc_top_properties.sv
// Port checker of the remote output terminal control block
`timescale 1ns/1ps
module rotc_top_properties
  import rotc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Write port and settings
  input wire logic panel_wr_en,
  input wire logic option_wr_en,
  input wire logic wr_ack,
  input wire logic wr_err,
  input wire logic [1:0] user_group_read_selection,
  input wire logic drive_reset,
  input wire logic power_fail,
  input wire logic nvm_save,
  // Option outputs
  input wire logic ext_option_fitted,
  input wire logic relay_option_fitted,
  input wire logic [rotc_pkg::EXT_N-1:0] extension_output_bits,
  input wire logic [rotc_pkg::RELAY_N-1:0] relay_option_bits
);
  logic wr_req;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Either source asks for a write
  assign wr_req = panel_wr_en | option_wr_en;
  sequence sel_blocked;
    wr_req && user_group_read_selection != USER_GROUP_ALL;
  endsequence
  sequence reset_blocked;
    wr_req && drive_reset;
  endsequence
  ack_err_excl_a: assert property (!(wr_ack && wr_err))
    else $error("ack and refusal together");
  ack_has_req_a: assert property (wr_ack |-> $past(wr_req))
    else $error("ack without request");
  sel_refuse_a: assert property (sel_blocked |=> wr_err && !wr_ack)
    else $error("write taken with wrong group selection");
  reset_refuse_a: assert property (reset_blocked |=> wr_err)
    else $error("write taken during drive reset");
  relay_gate_a: assert property (!relay_option_fitted && !drive_reset
    |=> relay_option_bits == '0) else $error("relay bits without option");
  ext_gate_a: assert property (!ext_option_fitted && !drive_reset
    |=> extension_output_bits == '0) else $error("ext bits without option");
  save_cause_a: assert property (nvm_save |-> $past(power_fail)
    && !$past(power_fail, 2) && !$past(drive_reset))
    else $error("save without power loss");
  save_pulse_a: assert property (nvm_save |=> !nvm_save)
    else $error("save longer than one cycle");
endmodule : rotc_top_properties
bind rotc_top rotc_top_properties props_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .panel_wr_en(panel_wr_en), .option_wr_en(option_wr_en), .wr_ack(wr_ack),
  .wr_err(wr_err), .user_group_read_selection(user_group_read_selection),
  .drive_reset(drive_reset), .power_fail(power_fail), .nvm_save(nvm_save),
  .ext_option_fitted(ext_option_fitted),
  .relay_option_fitted(relay_option_fitted),
  .extension_output_bits(extension_output_bits),
  .relay_option_bits(relay_option_bits));

// file: sim/rotc_nvm_model.sv
// Nonvolatile store that keeps the data words across power loss
`timescale 1ns/1ps
module rotc_nvm_model
(
  // Save request and values
  input wire logic ref_clk,
  input wire logic nvm_save,
  input wire logic [11:0] nvm_save_one,
  input wire logic [11:0] nvm_save_two,
  // Stored contents
  output logic [11:0] nvm_word_one,
  output logic [11:0] nvm_word_two
);
  // Blank store, written only on a save pulse; one process owns it
  initial
  begin
    nvm_word_one = 12'h000;
    nvm_word_two = 12'h000;
    forever
    begin
      @(posedge ref_clk);
      if (nvm_save)
      begin
        nvm_word_one <= nvm_save_one;
        nvm_word_two <= nvm_save_two;
      end
    end
  end
endmodule : rotc_nvm_model

// file: sim/rotc_top_test.sv
// Self-checking bench of the remote output terminal control block
`timescale 1ns/1ps
module rotc_top_test;
  import rotc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n, panel_wr_en, option_wr_en, rd_en, wr_ack, wr_err, nvm_save;
  logic parameter_write_protection, ext_option_fitted, relay_option_fitted;
  logic drive_reset, power_fail;
  logic [1:0] user_group_read_selection;
  logic [9:0] wr_param_num, rd_param_num;
  logic [15:0] wr_data, rd_data;
  logic [23:0] terminal_function_codes;
  logic [2:0] own_function_levels, terminal_out, relay_option_bits;
  logic [6:0] extension_output_bits;
  logic [7:0] nvm_mode;
  logic [11:0] nvm_word_one, nvm_word_two, nvm_save_one, nvm_save_two;
  logic [7:0] modes [4] = '{MODE_CLR_CLR, MODE_KEEP_CLR, MODE_CLR_KEEP,
    MODE_KEEP_KEEP};
  int error_cnt = 0;
  int check_count = 0;
  // Clock of 8 ns period
  always #4 ref_clk = ~ref_clk;
  rotc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .rd_en(rd_en),
    .panel_wr_en(panel_wr_en), .option_wr_en(option_wr_en),
    .wr_param_num(wr_param_num), .wr_data(wr_data), .wr_ack(wr_ack),
    .wr_err(wr_err), .rd_param_num(rd_param_num), .rd_data(rd_data),
    .user_group_read_selection(user_group_read_selection),
    .parameter_write_protection(parameter_write_protection),
    .terminal_function_codes(terminal_function_codes),
    .own_function_levels(own_function_levels), .power_fail(power_fail),
    .ext_option_fitted(ext_option_fitted), .drive_reset(drive_reset),
    .relay_option_fitted(relay_option_fitted), .nvm_mode(nvm_mode),
    .nvm_word_one(nvm_word_one), .nvm_word_two(nvm_word_two),
    .nvm_save(nvm_save), .nvm_save_one(nvm_save_one),
    .nvm_save_two(nvm_save_two), .terminal_out(terminal_out),
    .extension_output_bits(extension_output_bits),
    .relay_option_bits(relay_option_bits));
  rotc_nvm_model nvm_u (.ref_clk(ref_clk), .nvm_save(nvm_save),
    .nvm_save_one(nvm_save_one), .nvm_save_two(nvm_save_two),
    .nvm_word_one(nvm_word_one), .nvm_word_two(nvm_word_two));
  // Compare and count
  task check(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One write, then its answer
  task wr(input logic opt, input logic [9:0] n, input logic [15:0] d, ok);
    @(negedge ref_clk);
    panel_wr_en = !opt;
    option_wr_en = opt;
    wr_param_num = n;
    wr_data = d;
    @(negedge ref_clk);
    panel_wr_en = 1'b0;
    option_wr_en = 1'b0;
    check("answer", {14'h0, wr_ack, wr_err}, ok ? 16'h2 : 16'h1);
  endtask : wr
  // One read, then its data
  task rd(input logic [9:0] n, input logic [15:0] exp);
    @(negedge ref_clk);
    rd_en = 1'b1;
    rd_param_num = n;
    @(negedge ref_clk);
    rd_en = 1'b0;
    check("read", rd_data, exp);
  endtask : rd
  // Power-on reset with given stored mode
  task power_on(input logic [7:0] m);
    @(negedge ref_clk);
    rst_n = 1'b0;
    nvm_mode = m;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
  endtask : power_on
  task print_verdict;
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Cut a hang short
  initial
  begin
    #50000;
    error_cnt++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    {rst_n, panel_wr_en, option_wr_en, rd_en, drive_reset, power_fail} = '0;
    {ext_option_fitted, relay_option_fitted} = '0;
    parameter_write_protection = 1'b1;
    {wr_param_num, rd_param_num, wr_data} = '0;
    terminal_function_codes = {8'h05, FUNC_REMOTE_NEG, FUNC_REMOTE_POS};
    own_function_levels = 3'b100;
    user_group_read_selection = 2'h1;
    power_on(MODE_CLR_CLR);
    rd(NUM_DATA_WORD_ONE, 16'h0);
    wr(1'b0, NUM_DATA_WORD_ONE, 16'h1, 1'b0);
    user_group_read_selection = USER_GROUP_ALL;
    wr(1'b0, NUM_DATA_WORD_ONE, 16'h1000, 1'b0);
    wr(1'b0, NUM_RETENTION_MODE, 16'h2, 1'b0);
    foreach (modes[i])
    begin
      wr(1'b1, NUM_RETENTION_MODE, {8'h0, modes[i]}, 1'b1);
      rd(NUM_RETENTION_MODE, {8'h0, modes[i]});
    end
    wr(1'b0, NUM_DATA_WORD_ONE, 16'h7B, 1'b1);
    check("term", terminal_out, 3'b101);
    check("relay", relay_option_bits, 3'b000);
    relay_option_fitted = 1'b1;
    wr(1'b1, NUM_DATA_WORD_TWO, 16'h7F, 1'b1);
    check("relay", relay_option_bits, 3'b111);
    check("ext", extension_output_bits, 7'h00);
    ext_option_fitted = 1'b1;
    own_function_levels = 3'b000;
    @(negedge ref_clk);
    check("ext", extension_output_bits, 7'h7F);
    check("term", terminal_out, 3'b001);
    // Drive reset in keep mode freezes outputs
    drive_reset = 1'b1;
    own_function_levels = 3'b100;
    wr(1'b0, NUM_DATA_WORD_ONE, 16'h0, 1'b0);
    check("term", terminal_out, 3'b001);
    drive_reset = 1'b0;
    rd(NUM_DATA_WORD_ONE, 16'h7B);
    // Drive reset in clearing mode drops the words without a save
    wr(1'b0, NUM_RETENTION_MODE, {8'h0, MODE_KEEP_CLR}, 1'b1);
    drive_reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("term", terminal_out, 3'b110);
    drive_reset = 1'b0;
    rd(NUM_DATA_WORD_ONE, 16'h0);
    check("nvm", nvm_word_one, 12'h000);
    // Power loss saves, power on restores
    wr(1'b0, NUM_DATA_WORD_ONE, 16'hAB, 1'b1);
    wr(1'b1, NUM_DATA_WORD_TWO, 16'h5, 1'b1);
    power_fail = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("nvm", nvm_word_one, 12'h0AB);
    power_fail = 1'b0;
    power_on(MODE_KEEP_CLR);
    rd(NUM_DATA_WORD_TWO, 16'h5);
    check("term", terminal_out, 3'b101);
    power_on(MODE_CLR_KEEP);
    rd(NUM_DATA_WORD_ONE, 16'h0);
    rd(NUM_RETENTION_MODE, {8'h0, MODE_CLR_KEEP});
    print_verdict();
  end
endmodule : rotc_top_test
